// [hdl/aic_defs.svh]
`ifndef AIC_DEFS_SVH
`define AIC_DEFS_SVH
// voltages are codes of 10 mV, 0..500 for 0..5.00 V
`define AIC_CLK_PERIOD_NS 10
`define AIC_SAMPLE_PERIOD_MS 10
`define AIC_SAMPLE_CYCLES (`AIC_SAMPLE_PERIOD_MS * 1000000 / `AIC_CLK_PERIOD_NS)
`define AIC_PCT_W 10
`define AIC_VOLT_W 10
`define AIC_TIME_W 13
`define AIC_PCT_FULL 10'h3ff
`define AIC_PCT_ZERO 10'h000
`define AIC_RST_FLAG 1'b0
`endif

// [hdl/aic_pkg.sv]
`include "aic_defs.svh"
package aic_pkg;
  typedef logic [`AIC_PCT_W-1:0] pct_t;
  typedef logic [`AIC_VOLT_W-1:0] volt_t;
  // ramp time in 10 ms sample periods, 0..6500 for 0..65.00 s
  typedef logic [`AIC_TIME_W-1:0] rtime_t;
  typedef enum logic [1:0] {
    PH_WAIT = 2'b00,
    PH_CAPTURE = 2'b01,
    PH_COMPUTE = 2'b10,
    PH_RAMP = 2'b11
  } phase_e;
endpackage : aic_pkg

// [hdl/ramp_step.sv]
`include "aic_defs.svh"
module ramp_step
  import aic_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic step,
  input wire logic enable,
  input wire pct_t target,
  input wire rtime_t t_up,
  input wire rtime_t t_dn,
  output pct_t level
);
  pct_t level_q;
  pct_t rate_up;
  pct_t rate_dn;

  // full scale over t samples, rounded up so a ramp never overruns its time
  function automatic pct_t rate(input rtime_t t);
    logic [`AIC_TIME_W:0] q;
    q = (({4'h0, `AIC_PCT_FULL}) + {1'b0, t} - 14'h0001) / {1'b0, t};
    return q[`AIC_PCT_W-1:0];
  endfunction : rate

  assign rate_up = (t_up == '0) ? `AIC_PCT_FULL : rate(t_up);
  assign rate_dn = (t_dn == '0) ? `AIC_PCT_FULL : rate(t_dn);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_q <= `AIC_PCT_ZERO;
    end else if (step) begin
      if (!enable) begin
        level_q <= target;
      end else if (target > level_q) begin
        level_q <= (target - level_q <= rate_up) ? target : level_q + rate_up;
      end else begin
        level_q <= (level_q - target <= rate_dn) ? target : level_q - rate_dn;
      end
    end
  end
  assign level = level_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_ramp_rise;
    step && enable && target > level_q |=> level_q - $past(level_q) <= $past(rate_up);
  endproperty
  a_ramp_rise: assert property (p_ramp_rise) else $error("ramp rose too fast");

  property p_ramp_moves;
    step && enable && target != level_q |=> level_q != $past(level_q);
  endproperty
  a_ramp_moves: assert property (p_ramp_moves) else $error("ramp stalled");
endmodule : ramp_step

// [hdl/analog_input_conditioner.sv]
// Contract
// - sample input every 10 ms, recompute
// - zero percent inside center plus/minus deadband
// - ramps damp reported value toward raw
// - ramp duration scales with step size
// - ramp-down time covers full fall
// - ramp-up time covers full rise
// - center mode lower side own ramps
// - center mode upper side own ramps
// - calibration min/max map to 0/100%
// - input-low flag below minimum limit
// - input-high flag above maximum limit
// - input flags stick until application clears
// - reference-low flag below reference minimum
// - reference-high flag above reference maximum
// - inversion gives 100% at min
// - no center mode: proportional min to max
// - center mode: 0% center, 100% ends
// - center mode separate lower/upper outputs
// - auto limits halfway reference to calibration
// - ramps only when enabled
// - percent as ten-bit code 0..1023
`include "aic_defs.svh"
module analog_input_conditioner
  import aic_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `AIC_SAMPLE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire volt_t IN_VOLT,
  input wire volt_t REF_VOLT,
  input wire volt_t CAL_MIN,
  input wire volt_t CAL_CENTER,
  input wire volt_t CAL_MAX,
  input wire volt_t DEADBAND,
  input wire volt_t LIMIT_MIN,
  input wire volt_t LIMIT_MAX,
  input wire volt_t REF_LIMIT_MIN,
  input wire volt_t REF_LIMIT_MAX,
  input wire logic AUTO_LIMITS,
  input wire logic CENTER_EN,
  input wire logic INVERT_EN,
  input wire logic RAMP_EN,
  input wire rtime_t RAMP_LOWER_DOWN,
  input wire rtime_t RAMP_LOWER_UP,
  input wire rtime_t RAMP_UPPER_DOWN,
  input wire rtime_t RAMP_UPPER_UP,
  input wire logic CLEAR_INPUT_LOW,
  input wire logic CLEAR_INPUT_HIGH,
  input wire logic CLEAR_REF_LOW,
  input wire logic CLEAR_REF_HIGH,
  output pct_t VALUE,
  output pct_t LOWER_VALUE,
  output pct_t UPPER_VALUE,
  output logic VALUE_VALID,
  output logic INPUT_LOW_FAULT_FLAG,
  output logic INPUT_HIGH_FAULT_FLAG,
  output logic REFERENCE_LOW_FAULT_FLAG,
  output logic REFERENCE_HIGH_FAULT_FLAG
);
  localparam int CNT_W = $clog2(SAMPLE_CYCLES);

  logic [CNT_W-1:0] tick_cnt_q;
  logic tick;
  phase_e phase_q;
  volt_t samp_q;
  volt_t ref_q;
  pct_t raw_lo_q;
  pct_t raw_hi_q;
  logic center_q;
  pct_t lvl [2];
  pct_t value_q;
  pct_t lower_q;
  pct_t upper_q;
  logic valid_q;
  logic in_low_q;
  logic in_high_q;
  logic ref_low_q;
  logic ref_high_q;

  // 11-bit math keeps center plus deadband from overflowing; center minus deadband clamps at zero
  logic [10:0] c_minus;
  logic [10:0] c_plus;
  logic in_db;
  volt_t lim_min;
  volt_t lim_max;
  pct_t prop;
  pct_t lower_raw;
  pct_t upper_raw;

  function automatic pct_t scale(input logic [10:0] num, input logic [10:0] den);
    logic [20:0] p;
    p = {10'h000, num} * 21'd1023;
    if (den == 11'h000 || num >= den) begin
      return `AIC_PCT_FULL;
    end
    p = p / {10'h000, den};
    return p[`AIC_PCT_W-1:0];
  endfunction : scale

  // sample tick; the period is a parameter so a bench can shorten it
  assign tick = (tick_cnt_q == CNT_W'(SAMPLE_CYCLES - 1));
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      phase_q <= PH_WAIT;
    end else begin
      unique case (phase_q)
        PH_WAIT: if (tick) phase_q <= PH_CAPTURE;
        PH_CAPTURE: phase_q <= PH_COMPUTE;
        PH_COMPUTE: phase_q <= PH_RAMP;
        PH_RAMP: phase_q <= PH_WAIT;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      samp_q <= '0;
      ref_q <= '0;
    end else if (tick) begin
      samp_q <= IN_VOLT;
      ref_q <= REF_VOLT;
    end
  end

  assign c_minus = (CAL_CENTER > DEADBAND) ? {1'b0, CAL_CENTER - DEADBAND} : 11'h000;
  assign c_plus = {1'b0, CAL_CENTER} + {1'b0, DEADBAND};
  assign in_db = ({1'b0, samp_q} >= c_minus) && ({1'b0, samp_q} <= c_plus);

  // auto limits: min halfway to ground, max halfway to the reference
  always_comb begin
    lim_min = LIMIT_MIN;
    lim_max = LIMIT_MAX;
    if (AUTO_LIMITS) begin
      lim_min = CAL_MIN >> 1;
      lim_max = (ref_q > CAL_MAX) ? CAL_MAX + ((ref_q - CAL_MAX) >> 1) : CAL_MAX;
    end
  end

  assign prop = (samp_q <= CAL_MIN) ? `AIC_PCT_ZERO :
                scale({1'b0, samp_q - CAL_MIN}, {1'b0, CAL_MAX - CAL_MIN});
  assign lower_raw = ({1'b0, samp_q} >= c_minus) ? `AIC_PCT_ZERO :
                     scale(c_minus - {1'b0, samp_q}, c_minus - {1'b0, CAL_MIN});
  assign upper_raw = ({1'b0, samp_q} <= c_plus) ? `AIC_PCT_ZERO :
                     scale({1'b0, samp_q} - c_plus, {1'b0, CAL_MAX} - c_plus);

  // inversion is applied before the deadband, so center stays at zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      raw_lo_q <= `AIC_PCT_ZERO;
      raw_hi_q <= `AIC_PCT_ZERO;
      center_q <= 1'b0;
    end else if (phase_q == PH_COMPUTE) begin
      center_q <= CENTER_EN;
      if (CENTER_EN) begin
        raw_lo_q <= INVERT_EN ? `AIC_PCT_FULL - lower_raw : lower_raw;
        raw_hi_q <= INVERT_EN ? `AIC_PCT_FULL - upper_raw : upper_raw;
      end else begin
        raw_lo_q <= INVERT_EN ? `AIC_PCT_FULL - prop : prop;
        raw_hi_q <= `AIC_PCT_ZERO;
      end
      if (in_db) begin
        raw_lo_q <= `AIC_PCT_ZERO;
        raw_hi_q <= `AIC_PCT_ZERO;
      end
    end
  end

  // channel 0: main value or lower side; channel 1: upper side
  for (genvar g = 0; g < 2; g++) begin : g_ramp
    ramp_step u_ramp (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .step(phase_q == PH_RAMP),
      .enable(RAMP_EN),
      .target(g == 0 ? raw_lo_q : raw_hi_q),
      .t_up(g == 0 ? RAMP_LOWER_UP : RAMP_UPPER_UP),
      .t_dn(g == 0 ? RAMP_LOWER_DOWN : RAMP_UPPER_DOWN),
      .level(lvl[g])
    );
  end

  // one extra cycle after the ramp so all three outputs change together
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      value_q <= `AIC_PCT_ZERO;
      lower_q <= `AIC_PCT_ZERO;
      upper_q <= `AIC_PCT_ZERO;
      valid_q <= 1'b0;
    end else begin
      valid_q <= (phase_q == PH_RAMP);
      if (valid_q) begin
        lower_q <= center_q ? lvl[0] : `AIC_PCT_ZERO;
        upper_q <= center_q ? lvl[1] : `AIC_PCT_ZERO;
        value_q <= (center_q && lvl[1] != `AIC_PCT_ZERO) ? lvl[1] : lvl[0];
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      in_low_q <= `AIC_RST_FLAG;
      in_high_q <= `AIC_RST_FLAG;
      ref_low_q <= `AIC_RST_FLAG;
      ref_high_q <= `AIC_RST_FLAG;
    end else begin
      if (phase_q == PH_COMPUTE && samp_q < lim_min) begin
        in_low_q <= 1'b1;
      end else if (CLEAR_INPUT_LOW) begin
        in_low_q <= 1'b0;
      end
      if (phase_q == PH_COMPUTE && samp_q > lim_max) begin
        in_high_q <= 1'b1;
      end else if (CLEAR_INPUT_HIGH) begin
        in_high_q <= 1'b0;
      end
      if (phase_q == PH_COMPUTE && ref_q < REF_LIMIT_MIN) begin
        ref_low_q <= 1'b1;
      end else if (CLEAR_REF_LOW) begin
        ref_low_q <= 1'b0;
      end
      if (phase_q == PH_COMPUTE && ref_q > REF_LIMIT_MAX) begin
        ref_high_q <= 1'b1;
      end else if (CLEAR_REF_HIGH) begin
        ref_high_q <= 1'b0;
      end
    end
  end

  assign VALUE = value_q;
  assign LOWER_VALUE = lower_q;
  assign UPPER_VALUE = upper_q;
  assign VALUE_VALID = valid_q;
  assign INPUT_LOW_FAULT_FLAG = in_low_q;
  assign INPUT_HIGH_FAULT_FLAG = in_high_q;
  assign REFERENCE_LOW_FAULT_FLAG = ref_low_q;
  assign REFERENCE_HIGH_FAULT_FLAG = ref_high_q;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  property p_tick_spacing;
    tick |=> !tick [*2] ##0 tick_cnt_q == CNT_W'(1);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("sample tick spacing wrong");

  property p_valid_after_tick;
    tick |-> ##4 valid_q;
  endproperty
  a_valid_after_tick: assert property (p_valid_after_tick) else $error("no value four cycles after sample");

  property p_deadband_zero;
    phase_q == PH_COMPUTE && in_db |=> raw_lo_q == `AIC_PCT_ZERO && raw_hi_q == `AIC_PCT_ZERO;
  endproperty
  a_deadband_zero: assert property (p_deadband_zero) else $error("deadband not zero");

  property p_full_at_max;
    phase_q == PH_COMPUTE && !CENTER_EN && !INVERT_EN && !in_db && samp_q >= CAL_MAX && CAL_MAX > CAL_MIN
      |=> raw_lo_q == `AIC_PCT_FULL;
  endproperty
  a_full_at_max: assert property (p_full_at_max) else $error("max calibration not full scale");

  property p_invert_min;
    phase_q == PH_COMPUTE && !CENTER_EN && INVERT_EN && !in_db && samp_q <= CAL_MIN
      |=> raw_lo_q == `AIC_PCT_FULL;
  endproperty
  a_invert_min: assert property (p_invert_min) else $error("inverted min not full scale");

  property p_no_ramp;
    valid_q && !$past(RAMP_EN, 1) |=> VALUE == $past(raw_lo_q, 2) || center_q;
  endproperty
  a_no_ramp: assert property (p_no_ramp) else $error("undamped value differs from raw");

  property p_in_low;
    phase_q == PH_COMPUTE && samp_q < lim_min |=> INPUT_LOW_FAULT_FLAG;
  endproperty
  a_in_low: assert property (p_in_low) else $error("input low flag missed");

  property p_in_high;
    phase_q == PH_COMPUTE && samp_q > lim_max |=> INPUT_HIGH_FAULT_FLAG;
  endproperty
  a_in_high: assert property (p_in_high) else $error("input high flag missed");

  property p_sticky;
    INPUT_LOW_FAULT_FLAG && !CLEAR_INPUT_LOW |=> INPUT_LOW_FAULT_FLAG;
  endproperty
  a_sticky: assert property (p_sticky) else $error("input low flag dropped");

  property p_ref_low;
    phase_q == PH_COMPUTE && ref_q < REF_LIMIT_MIN |=> REFERENCE_LOW_FAULT_FLAG;
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("reference low flag missed");

  property p_ref_high;
    phase_q == PH_COMPUTE && ref_q > REF_LIMIT_MAX |=> REFERENCE_HIGH_FAULT_FLAG;
  endproperty
  a_ref_high: assert property (p_ref_high) else $error("reference high flag missed");

  property p_side_exclusive;
    valid_q && !center_q |=> LOWER_VALUE == `AIC_PCT_ZERO && UPPER_VALUE == `AIC_PCT_ZERO;
  endproperty
  a_side_exclusive: assert property (p_side_exclusive) else $error("side outputs without center mode");

  property p_sticky_high;
    INPUT_HIGH_FAULT_FLAG && !CLEAR_INPUT_HIGH |=> INPUT_HIGH_FAULT_FLAG;
  endproperty
  a_sticky_high: assert property (p_sticky_high) else $error("input high flag dropped");

  property p_clear_low;
    CLEAR_INPUT_LOW && !(phase_q == PH_COMPUTE && samp_q < lim_min) |=> !INPUT_LOW_FAULT_FLAG;
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("input low flag not cleared");

  property p_outputs_stand;
    !valid_q |=> $stable(VALUE) && $stable(LOWER_VALUE) && $stable(UPPER_VALUE);
  endproperty
  a_outputs_stand: assert property (p_outputs_stand) else $error("outputs moved between samples");

  property p_valid_pulse;
    valid_q |=> !valid_q;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("value valid longer than one cycle");

  property p_zero_below_min;
    phase_q == PH_COMPUTE && !CENTER_EN && !INVERT_EN && samp_q <= CAL_MIN
      |=> raw_lo_q == `AIC_PCT_ZERO;
  endproperty
  a_zero_below_min: assert property (p_zero_below_min) else $error("min calibration not zero");

  c_center_upper: cover property (valid_q && center_q ##1 UPPER_VALUE != `AIC_PCT_ZERO);
  c_auto_high: cover property (AUTO_LIMITS && INPUT_HIGH_FAULT_FLAG);
  c_ramping: cover property (RAMP_EN && valid_q ##1 VALUE != raw_lo_q);
  c_flag_clear: cover property (INPUT_LOW_FAULT_FLAG ##1 !INPUT_LOW_FAULT_FLAG);
  c_ref_fault: cover property (REFERENCE_HIGH_FAULT_FLAG && REFERENCE_LOW_FAULT_FLAG);
endmodule : analog_input_conditioner

// [testbench/sensor_model.sv]
module sensor_model
  import aic_pkg::*;
(
  input wire logic clk,
  input wire volt_t want_volt,
  input wire volt_t want_ref,
  output volt_t in_volt,
  output volt_t ref_volt
);
  timeunit 1ns;
  timeprecision 1ns;
  // wiper moves only on the falling edge, never at the sampling edge
  always @(negedge clk) begin
    in_volt <= want_volt;
    ref_volt <= want_ref;
  end
endmodule : sensor_model

// [testbench/tb_top.sv]
module tb_top
  import aic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SAMPLES = 16;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  volt_t want_volt = 10'h000, want_ref = 10'h1c2, in_volt, ref_volt;
  volt_t cmin = 10'h032, cctr = 10'h0fa, cmax = 10'h1c2, db = 10'h00a;
  volt_t lmin = 10'h01e, lmax = 10'h1d6, rlmin = 10'h1a9, rlmax = 10'h1db;
  logic auto = 1'b0, cen = 1'b0, inv = 1'b0, ren = 1'b0;
  rtime_t rld = 13'h0000, rlu = 13'h0000, rud = 13'h0000, ruu = 13'h0000;
  logic [3:0] clr = 4'h0;
  pct_t value, lo_v, up_v;
  logic valid, f_il, f_ih, f_rl, f_rh;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  sensor_model src_u (.clk(sys_clk), .want_volt(want_volt), .want_ref(want_ref),
    .in_volt(in_volt), .ref_volt(ref_volt));

  analog_input_conditioner #(.SAMPLE_CYCLES(SAMPLES)) dut_u (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .IN_VOLT(in_volt), .REF_VOLT(ref_volt),
    .CAL_MIN(cmin), .CAL_CENTER(cctr), .CAL_MAX(cmax), .DEADBAND(db),
    .LIMIT_MIN(lmin), .LIMIT_MAX(lmax), .REF_LIMIT_MIN(rlmin), .REF_LIMIT_MAX(rlmax),
    .AUTO_LIMITS(auto), .CENTER_EN(cen), .INVERT_EN(inv), .RAMP_EN(ren),
    .RAMP_LOWER_DOWN(rld), .RAMP_LOWER_UP(rlu), .RAMP_UPPER_DOWN(rud), .RAMP_UPPER_UP(ruu),
    .CLEAR_INPUT_LOW(clr[3]), .CLEAR_INPUT_HIGH(clr[2]), .CLEAR_REF_LOW(clr[1]),
    .CLEAR_REF_HIGH(clr[0]), .VALUE(value), .LOWER_VALUE(lo_v), .UPPER_VALUE(up_v),
    .VALUE_VALID(valid), .INPUT_LOW_FAULT_FLAG(f_il), .INPUT_HIGH_FAULT_FLAG(f_ih),
    .REFERENCE_LOW_FAULT_FLAG(f_rl), .REFERENCE_HIGH_FAULT_FLAG(f_rh)
  );

  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // new level lands before the next tick; outputs read one edge after the valid pulse
  task automatic run(input volt_t v, input pct_t ev, input pct_t el, input pct_t eh);
    int n;
    @(negedge sys_clk);
    want_volt = v;
    n = 0;
    while (valid !== 1'b1 && n < 4 * SAMPLES) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 4 * SAMPLES) begin
      n_fail++;
    end
    @(negedge sys_clk);
    chk({9'h000, valid}, 10'h000);
    chk(value, ev);
    chk(lo_v, el);
    chk(up_v, eh);
  endtask : run

  task automatic flags(input logic [3:0] exp);
    chk({6'h00, f_il, f_ih, f_rl, f_rh}, {6'h00, exp});
  endtask : flags

  task automatic clear(input logic [3:0] mask);
    @(negedge sys_clk);
    clr = mask;
    @(negedge sys_clk);
    clr = 4'h0;
  endtask : clear

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    run(10'h1c2, 10'h3ff, 10'h000, 10'h000);
    run(10'h032, 10'h000, 10'h000, 10'h000);
    run(10'h082, 10'h0cc, 10'h000, 10'h000);
    run(10'h0ff, 10'h000, 10'h000, 10'h000);
    inv = 1'b1;
    run(10'h082, 10'h333, 10'h000, 10'h000);
    run(10'h032, 10'h3ff, 10'h000, 10'h000);
    inv = 1'b0;
    cen = 1'b1;
    run(10'h0fa, 10'h000, 10'h000, 10'h000);
    run(10'h1c2, 10'h3ff, 10'h000, 10'h3ff);
    run(10'h032, 10'h3ff, 10'h3ff, 10'h000);
    run(10'h091, 10'h1ff, 10'h1ff, 10'h000);
    cen = 1'b0;
    rlu = 13'h0004;
    rld = 13'h0002;
    ruu = 13'h0002;
    rud = 13'h0001;
    ren = 1'b1;
    run(10'h032, 10'h000, 10'h000, 10'h000);
    run(10'h10e, 10'h100, 10'h000, 10'h000);
    run(10'h10e, 10'h200, 10'h000, 10'h000);
    run(10'h10e, 10'h232, 10'h000, 10'h000);
    run(10'h1c2, 10'h332, 10'h000, 10'h000);
    run(10'h1c2, 10'h3ff, 10'h000, 10'h000);
    run(10'h032, 10'h1ff, 10'h000, 10'h000);
    run(10'h032, 10'h000, 10'h000, 10'h000);
    ren = 1'b0;
    run(10'h1c2, 10'h3ff, 10'h000, 10'h000);
    cen = 1'b1;
    run(10'h0fa, 10'h000, 10'h000, 10'h000);
    ren = 1'b1;
    run(10'h1c2, 10'h200, 10'h000, 10'h200);
    run(10'h1c2, 10'h3ff, 10'h000, 10'h3ff);
    run(10'h032, 10'h100, 10'h100, 10'h000);
    run(10'h032, 10'h200, 10'h200, 10'h000);
    run(10'h0fa, 10'h000, 10'h000, 10'h000);
    cen = 1'b0;
    ren = 1'b0;
    run(10'h014, 10'h000, 10'h000, 10'h000);
    flags(4'b1000);
    run(10'h082, 10'h0cc, 10'h000, 10'h000);
    flags(4'b1000);
    clear(4'b1000);
    flags(4'b0000);
    run(10'h1e0, 10'h3ff, 10'h000, 10'h000);
    flags(4'b0100);
    want_ref = 10'h190;
    run(10'h082, 10'h0cc, 10'h000, 10'h000);
    flags(4'b0110);
    want_ref = 10'h1e0;
    run(10'h082, 10'h0cc, 10'h000, 10'h000);
    flags(4'b0111);
    clear(4'b0111);
    flags(4'b0000);
    // auto limits: low at half of min calibration, high halfway to the reference
    want_ref = 10'h1d6;
    auto = 1'b1;
    run(10'h01a, 10'h000, 10'h000, 10'h000);
    flags(4'b0000);
    run(10'h018, 10'h000, 10'h000, 10'h000);
    flags(4'b1000);
    clear(4'b1000);
    run(10'h1ce, 10'h3ff, 10'h000, 10'h000);
    flags(4'b0100);
    // mid-run reset: outputs and flags drop, sampling restarts
    @(negedge sys_clk);
    rst_b = 1'b0;
    @(negedge sys_clk);
    chk(value, 10'h000);
    flags(4'b0000);
    rst_b = 1'b1;
    run(10'h082, 10'h0cc, 10'h000, 10'h000);
    flags(4'b0000);
    close_out();
  end
endmodule : tb_top
